// ---- inc/debug_halt_config_map.svh ----
// Offsets, field positions, reset value and widths of the debug halt configuration register.
`ifndef DEBUG_HALT_CONFIG_MAP_SVH
`define DEBUG_HALT_CONFIG_MAP_SVH

// ==========================================================================
// Register location and reset value
// ==========================================================================
`define DHC_CSR_ADDR_W      12
`define DHC_DATA_W          32
`define DHC_CSR_ADDR        12'h7c0
`define DHC_RESET_VALUE     32'h0000_0000
// Run-mode clock controls: core and bus clocks on, system clock, digital power kept.
`define DHC_RUN_CLK_CTL     4'b1101

// ==========================================================================
// Field positions
// ==========================================================================
`define DHC_TIMER_B_BIT     13
`define DHC_TIMER_A_BIT     12
`define DHC_WINDOW_DOG_BIT  9
`define DHC_INDEP_DOG_BIT   8
`define DHC_STANDBY_BIT     2
`define DHC_STOP_BIT        1
`define DHC_SLEEP_BIT       0

`endif

// ---- inc/debug_halt_config_pkg.sv ----
// Types shared by the debug halt configuration block and its bench.
`include "debug_halt_config_map.svh"

package debug_halt_config_pkg;

    // ======================================================================
    // Core control and status register request
    // ======================================================================
    typedef struct packed {
        logic                        valid;
        logic                        write;
        logic [`DHC_CSR_ADDR_W-1:0]  addr;
        logic [`DHC_DATA_W-1:0]      wdata;
    } csr_req_type;

    // ======================================================================
    // Counter hold outputs
    // ======================================================================
    typedef struct packed {
        logic timerB;
        logic timerA;
        logic windowDog;
        logic indepDog;
    } freeze_type;

    // ======================================================================
    // Clock and power controls
    // ======================================================================
    typedef struct packed {
        logic fclkOn;
        logic hclkOn;
        logic useInternalOsc;
        logic keepDigitalPower;
    } clk_ctl_type;

    // ======================================================================
    // Power mode states
    // ======================================================================
    typedef enum logic [3:0] {
        RUN_ST     = 4'b0001,
        SLEEP_ST   = 4'b0010,
        STOP_ST    = 4'b0100,
        STANDBY_ST = 4'b1000
    } power_state_type;

endpackage

// ---- verilog/debug_halt_config.sv ----
// Debug halt configuration register with counter freezes and low-power clock control.
`timescale 1ns/1ps
`include "debug_halt_config_map.svh"

// Function
// - In debug halt, timer freeze bits 13 and 12 hold their timer counters.
// - In debug halt, bit 9 set holds the window watchdog counter.
// - In debug halt, bit 8 set holds the independent watchdog counter.
// - Bit 2 set keeps standby powered with core clocks from internal oscillator.
// - Standby exit behaves as reset yet flags that standby was just left.
// - Bit 1 set feeds core clocks from internal oscillator in stop; clear gates all.
// - Stop exit restores reset clock setup with internal oscillator off; software reconfigures.
// - Bit 0 set keeps both clocks in sleep; clear keeps only free-running clock.
// - Sleep leaves clock configuration untouched, no restore on wake.
// - Register sits at CSR 0x7C0, all bits read-write, reset to zero.
module debug_halt_config (
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                nrst,
    // Core register port
    input  wire debug_halt_config_pkg::csr_req_type  csrReq,
    output logic                                     csrAck,
    output logic [`DHC_DATA_W-1:0]                   csrRdata,
    // Core state and power requests
    input  wire logic                                coreHalted,
    input  wire logic                                sleepReq,
    input  wire logic                                stopReq,
    input  wire logic                                standbyReq,
    input  wire logic                                wakeEvent,
    input  wire logic                                standbyFlagClear,
    // Counter holds
    output debug_halt_config_pkg::freeze_type        freezeHold,
    // Clock and power control
    output debug_halt_config_pkg::clk_ctl_type       clkCtl,
    output logic                                     clkCfgRestore,
    output logic                                     standbyResetReq,
    output logic                                     standbyExitFlag,
    output debug_halt_config_pkg::power_state_type   powerState
);

    // ======================================================================
    // Register access
    // ======================================================================
    logic [`DHC_DATA_W-1:0]                 cfg_ff;
    logic [`DHC_DATA_W-1:0]                 rdata_ff;
    logic                                   ack_ff;
    logic                                   csrHit;

    assign csrHit = csrReq.valid && (csrReq.addr == `DHC_CSR_ADDR);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_ff <= `DHC_RESET_VALUE;
        end else if (csrHit && csrReq.write) begin
            cfg_ff <= csrReq.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= `DHC_RESET_VALUE;
        end else begin
            ack_ff <= csrHit;
            if (csrHit && !csrReq.write) begin
                rdata_ff <= cfg_ff;
            end
        end
    end

    assign csrAck   = ack_ff;
    assign csrRdata = rdata_ff;

    // ======================================================================
    // Counter holds
    // ======================================================================
    debug_halt_config_pkg::freeze_type      hold_ff;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hold_ff <= '0;
        end else begin
            hold_ff.timerB    <= coreHalted && cfg_ff[`DHC_TIMER_B_BIT];
            hold_ff.timerA    <= coreHalted && cfg_ff[`DHC_TIMER_A_BIT];
            hold_ff.windowDog <= coreHalted && cfg_ff[`DHC_WINDOW_DOG_BIT];
            hold_ff.indepDog  <= coreHalted && cfg_ff[`DHC_INDEP_DOG_BIT];
        end
    end

    assign freezeHold = hold_ff;

    // ======================================================================
    // Power mode sequencing
    // ======================================================================
    debug_halt_config_pkg::power_state_type state_ff;
    debug_halt_config_pkg::power_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            debug_halt_config_pkg::RUN_ST: begin
                if (standbyReq) begin
                    nxt_state = debug_halt_config_pkg::STANDBY_ST;
                end else if (stopReq) begin
                    nxt_state = debug_halt_config_pkg::STOP_ST;
                end else if (sleepReq) begin
                    nxt_state = debug_halt_config_pkg::SLEEP_ST;
                end
            end
            debug_halt_config_pkg::SLEEP_ST,
            debug_halt_config_pkg::STOP_ST,
            debug_halt_config_pkg::STANDBY_ST: begin
                if (wakeEvent) begin
                    nxt_state = debug_halt_config_pkg::RUN_ST;
                end
            end
            default: begin
                nxt_state = debug_halt_config_pkg::RUN_ST;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= debug_halt_config_pkg::RUN_ST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign powerState = state_ff;

    // ======================================================================
    // Clock and power control, following the state being entered
    // ======================================================================
    debug_halt_config_pkg::clk_ctl_type     clk_ff;
    debug_halt_config_pkg::clk_ctl_type     nxt_clk;

    always_comb begin
        nxt_clk = `DHC_RUN_CLK_CTL;
        case (nxt_state)
            debug_halt_config_pkg::SLEEP_ST: begin
                nxt_clk.fclkOn         = 1'b1;
                nxt_clk.hclkOn         = cfg_ff[`DHC_SLEEP_BIT];
                nxt_clk.useInternalOsc = 1'b0;
            end
            debug_halt_config_pkg::STOP_ST: begin
                nxt_clk.fclkOn         = cfg_ff[`DHC_STOP_BIT];
                nxt_clk.hclkOn         = cfg_ff[`DHC_STOP_BIT];
                nxt_clk.useInternalOsc = cfg_ff[`DHC_STOP_BIT];
            end
            debug_halt_config_pkg::STANDBY_ST: begin
                nxt_clk.fclkOn           = cfg_ff[`DHC_STANDBY_BIT];
                nxt_clk.hclkOn           = cfg_ff[`DHC_STANDBY_BIT];
                nxt_clk.useInternalOsc   = cfg_ff[`DHC_STANDBY_BIT];
                nxt_clk.keepDigitalPower = cfg_ff[`DHC_STANDBY_BIT];
            end
            default: begin
                nxt_clk.fclkOn = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            clk_ff <= `DHC_RUN_CLK_CTL;
        end else begin
            clk_ff <= nxt_clk;
        end
    end

    assign clkCtl = clk_ff;

    // ======================================================================
    // Wake-up effects
    // ======================================================================
    logic                                   stopExit;
    logic                                   standbyExit;
    logic                                   restore_ff;
    logic                                   stbyRst_ff;
    logic                                   stbyFlag_ff;

    assign stopExit    = (state_ff == debug_halt_config_pkg::STOP_ST) && wakeEvent;
    assign standbyExit = (state_ff == debug_halt_config_pkg::STANDBY_ST) && wakeEvent;

    // Clock setup returns to its reset state after stop, whatever the stop bit.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            restore_ff <= 1'b0;
        end else begin
            restore_ff <= stopExit || standbyExit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stbyRst_ff <= 1'b0;
        end else begin
            stbyRst_ff <= standbyExit;
        end
    end

    // The set from a standby exit wins over a clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stbyFlag_ff <= 1'b0;
        end else if (standbyExit) begin
            stbyFlag_ff <= 1'b1;
        end else if (standbyFlagClear) begin
            stbyFlag_ff <= 1'b0;
        end
    end

    assign clkCfgRestore   = restore_ff;
    assign standbyResetReq = stbyRst_ff;
    assign standbyExitFlag = stbyFlag_ff;

    // ======================================================================
    // Assertions
    // ======================================================================
    property p_timer_hold;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> (freezeHold.timerA == ($past(coreHalted) && $past(cfg_ff[`DHC_TIMER_A_BIT])))
              && (freezeHold.timerB == ($past(coreHalted) && $past(cfg_ff[`DHC_TIMER_B_BIT])));
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer hold wrong");

    property p_window_hold;
        @(posedge core_clk) disable iff (!nrst)
        (coreHalted && cfg_ff[`DHC_WINDOW_DOG_BIT]) |=> freezeHold.windowDog;
    endproperty
    a_window_hold: assert property (p_window_hold) else $error("window hold missing");

    property p_indep_hold;
        @(posedge core_clk) disable iff (!nrst)
        !(coreHalted && cfg_ff[`DHC_INDEP_DOG_BIT]) |=> !freezeHold.indepDog;
    endproperty
    a_indep_hold: assert property (p_indep_hold) else $error("indep hold spurious");

    property p_standby_power;
        @(posedge core_clk) disable iff (!nrst)
        (state_ff == debug_halt_config_pkg::STANDBY_ST)
            |-> (clkCtl.keepDigitalPower == $past(cfg_ff[`DHC_STANDBY_BIT]))
             && (clkCtl.hclkOn == $past(cfg_ff[`DHC_STANDBY_BIT]));
    endproperty
    a_standby_power: assert property (p_standby_power) else $error("standby power wrong");

    property p_standby_exit;
        @(posedge core_clk) disable iff (!nrst)
        standbyExit |=> standbyResetReq && standbyExitFlag ##1 !standbyResetReq;
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby exit wrong");

    property p_stop_clocks;
        @(posedge core_clk) disable iff (!nrst)
        (state_ff == debug_halt_config_pkg::STOP_ST)
            |-> (clkCtl.fclkOn == $past(cfg_ff[`DHC_STOP_BIT]))
             && (clkCtl.useInternalOsc == $past(cfg_ff[`DHC_STOP_BIT]));
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("stop clocks wrong");

    property p_stop_restore;
        @(posedge core_clk) disable iff (!nrst)
        stopExit |=> clkCfgRestore ##1 !clkCfgRestore;
    endproperty
    a_stop_restore: assert property (p_stop_restore) else $error("no restore on stop exit");

    property p_sleep_clocks;
        @(posedge core_clk) disable iff (!nrst)
        (state_ff == debug_halt_config_pkg::SLEEP_ST)
            |-> clkCtl.fclkOn && (clkCtl.hclkOn == $past(cfg_ff[`DHC_SLEEP_BIT]));
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clocks wrong");

    property p_sleep_keep;
        @(posedge core_clk) disable iff (!nrst)
        ((state_ff == debug_halt_config_pkg::SLEEP_ST) && wakeEvent) |=> !clkCfgRestore;
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("restore after sleep");

    property p_csr_readback;
        @(posedge core_clk) disable iff (!nrst)
        (csrHit && csrReq.write) ##1 (csrHit && !csrReq.write)
            |=> csrAck && (csrRdata == $past(csrReq.wdata, 2));
    endproperty
    a_csr_readback: assert property (p_csr_readback) else $error("readback mismatch");

endmodule // debug_halt_config

// ---- tb/tb.sv ----
// Self-checking bench for the debug halt configuration register block.
`timescale 1ns/1ps
`include "debug_halt_config_map.svh"

module tb;
    // ======================================================================
    // Signals
    // ======================================================================
    logic                                   core_clk = 1'b0;
    logic                                   nrst = 1'b0;
    debug_halt_config_pkg::csr_req_type     csrReq = '0;
    logic                                   csrAck;
    logic [`DHC_DATA_W-1:0]                 csrRdata;
    logic                                   coreHalted = 1'b0;
    logic                                   sleepReq = 1'b0;
    logic                                   stopReq = 1'b0;
    logic                                   standbyReq = 1'b0;
    logic                                   wakeEvent = 1'b0;
    logic                                   standbyFlagClear = 1'b0;
    debug_halt_config_pkg::freeze_type      freezeHold;
    debug_halt_config_pkg::clk_ctl_type     clkCtl;
    logic                                   clkCfgRestore;
    logic                                   standbyResetReq;
    logic                                   standbyExitFlag;
    debug_halt_config_pkg::power_state_type powerState;
    int                                     fails = 0;
    int                                     compares = 0;
    logic [31:0]                            rd;
    logic [31:0]                            cfg;
    logic [11:0]                            badAddr;
    int                                     seedDummy;

    always #10 core_clk = ~core_clk;

    debug_halt_config dut_u (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .csrReq           (csrReq),
        .csrAck           (csrAck),
        .csrRdata         (csrRdata),
        .coreHalted       (coreHalted),
        .sleepReq         (sleepReq),
        .stopReq          (stopReq),
        .standbyReq       (standbyReq),
        .wakeEvent        (wakeEvent),
        .standbyFlagClear (standbyFlagClear),
        .freezeHold       (freezeHold),
        .clkCtl           (clkCtl),
        .clkCfgRestore    (clkCfgRestore),
        .standbyResetReq  (standbyResetReq),
        .standbyExitFlag  (standbyExitFlag),
        .powerState       (powerState)
    );

    // ======================================================================
    // Compare tasks and expectations
    // ======================================================================
    task automatic chk1(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask

    task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [3:0] exp_freeze(input logic [31:0] c, input logic h);
        exp_freeze = {h & c[`DHC_TIMER_B_BIT], h & c[`DHC_TIMER_A_BIT],
                      h & c[`DHC_WINDOW_DOG_BIT], h & c[`DHC_INDEP_DOG_BIT]};
    endfunction

    // One register access, then an idle edge so that valid never drops and rises at once.
    task automatic csr_access(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                              input logic hit, output logic [31:0] rdata);
        csrReq = '{valid: 1'b1, write: wr, addr: addr, wdata: data};
        @(negedge core_clk);
        csrReq.valid = 1'b0;
        chk1(csrAck, hit, "register ack");
        rdata = csrRdata;
        @(negedge core_clk);
    endtask

    // Enter a low-power mode (0 sleep, 1 stop, 2 standby) and wake again.
    task automatic power_cycle(input int mode);
        logic       b;
        logic [3:0] expClk;
        logic [3:0] mask;
        b = cfg[mode];
        expClk = (mode == 0) ? {1'b1, b, 1'b0, 1'b1} : {b, b, b, (mode == 2) ? b : 1'b1};
        mask = (mode == 2) ? 4'hf : 4'he;
        sleepReq = (mode == 0);
        stopReq = (mode == 1);
        standbyReq = (mode == 2);
        @(negedge core_clk);
        sleepReq = 1'b0;
        stopReq = 1'b0;
        standbyReq = 1'b0;
        chk4(powerState, 4'h1 << (mode + 1), "mode entry");
        chk4(clkCtl & mask, expClk & mask, "mode clocks");
        wakeEvent = 1'b1;
        @(negedge core_clk);
        wakeEvent = 1'b0;
        chk4(powerState, 4'h1, "wake state");
        chk4(clkCtl, 4'hd, "wake clocks");
        chk1(clkCfgRestore, mode != 0, "clock restore");
        chk1(standbyResetReq, mode == 2, "standby reset");
        @(negedge core_clk);
        chk1(clkCfgRestore, 1'b0, "restore pulse");
        chk1(standbyResetReq, 1'b0, "reset pulse");
        if (mode == 2) begin
            chk1(standbyExitFlag, 1'b1, "exit flag");
            standbyFlagClear = 1'b1;
            @(negedge core_clk);
            standbyFlagClear = 1'b0;
            chk1(standbyExitFlag, 1'b0, "flag clear");
        end
    endtask

    task automatic complete_run;
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Watchdog: the tests need a few hundred cycles, so 5000 means a hang.
    // ======================================================================
    initial begin
        #(20 * 5000);
        fails++;
        complete_run();
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        seedDummy = $urandom(32'h3fc78ae4);
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        chk4(powerState, 4'h1, "reset state");
        chk4(clkCtl, 4'hd, "reset clocks");
        chk4(freezeHold, 4'h0, "reset holds");
        chk32(csrRdata, 32'h0, "reset rdata");
        @(negedge core_clk);
        csr_access(1'b0, `DHC_CSR_ADDR, 32'h0, 1'b1, rd);
        chk32(rd, `DHC_RESET_VALUE, "reset value");
        for (int i = 0; i < 40; i++) begin
            cfg = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            csr_access(1'b1, `DHC_CSR_ADDR, cfg, 1'b1, rd);
            coreHalted = (i < 2) ? 1'b1 : 1'($urandom);
            csr_access(1'b0, `DHC_CSR_ADDR, 32'h0, 1'b1, rd);
            chk32(rd, cfg, "read back");
            chk4(freezeHold, exp_freeze(cfg, coreHalted), "holds");
            badAddr = 12'($urandom);
            if (badAddr == `DHC_CSR_ADDR) begin
                badAddr = badAddr ^ 12'h001;
            end
            csr_access(1'b1, badAddr, ~cfg, 1'b0, rd);
            csr_access(1'b0, badAddr, 32'h0, 1'b0, rd);
            chk32(rd, cfg, "unmapped read keeps rdata");
            csr_access(1'b0, `DHC_CSR_ADDR, 32'h0, 1'b1, rd);
            chk32(rd, cfg, "unmapped write ignored");
        end
        coreHalted = 1'b0;
        wakeEvent = 1'b1;
        @(negedge core_clk);
        wakeEvent = 1'b0;
        chk4(powerState, 4'h1, "wake in run ignored");
        for (int i = 0; i < 6; i++) begin
            cfg = $urandom;
            cfg[i % 3] = (i >= 3);
            csr_access(1'b1, `DHC_CSR_ADDR, cfg, 1'b1, rd);
            power_cycle(i % 3);
        end
        // Enter stop with the core halted so that the mid-run reset has state to clear.
        coreHalted = 1'b1;
        stopReq = 1'b1;
        @(negedge core_clk);
        stopReq = 1'b0;
        chk4(powerState, 4'h4, "stop before reset");
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        chk4(powerState, 4'h1, "state after second reset");
        chk4(clkCtl, 4'hd, "clocks after second reset");
        chk32(csrRdata, 32'h0, "rdata after second reset");
        @(negedge core_clk);
        chk4(freezeHold, 4'h0, "holds after second reset");
        csr_access(1'b0, `DHC_CSR_ADDR, 32'h0, 1'b1, rd);
        chk32(rd, 32'h0, "value after second reset");
        complete_run();
    end
endmodule // tb
